// >>> rtl/pmb_pkg.sv
package pmb_pkg;

  // management bus addressing
  localparam logic [4:0] PHY1_ADDR_RST   = 5'h01;
  localparam logic [4:0] PHY2_ADDR_RST   = 5'h02;
  localparam logic [4:0] REG_CONTROL     = 5'h00;
  localparam logic [4:0] REG_LAST_STD    = 5'h05;
  localparam logic [4:0] REG_CABLE_DIAG  = 5'h1d;
  localparam logic [4:0] REG_SPECIAL     = 5'h1f;

  // switch-side register addresses and fields
  localparam logic [7:0] SREG_GLOBAL_ADDR = 8'h0f;
  localparam int         ADDR_FIELD_LSB   = 3;
  localparam int         ADDR_FIELD_MSB   = 7;
  localparam logic [7:0] SREG_P1_CTL28    = 8'h1c;
  localparam logic [7:0] SREG_P1_CTL29    = 8'h1d;
  localparam logic [7:0] SREG_P1_CTL31    = 8'h1f;
  localparam logic [7:0] SREG_PHY_STRIDE  = 8'h10;

  // control register bit positions
  localparam int CB_LOOPBACK = 14;
  localparam int CB_FORCE100 = 13;
  localparam int CB_AUTONEG  = 12;
  localparam int CB_PWRDN    = 11;
  localparam int CB_RESTART  = 9;
  localparam int CB_DUPLEX   = 8;
  localparam int CB_VARIANT  = 5;
  localparam int CB_STRAIGHT = 4;
  localparam int CB_MDIXDIS  = 3;
  localparam int CB_FEFDIS   = 2;
  localparam int CB_TXDIS    = 1;
  localparam int CB_LEDDIS   = 0;
  localparam logic [15:0] CTRL_RST = 16'h1020;

  // switch port register bit positions
  localparam int P28_AUTONEG  = 7;
  localparam int P28_FORCE100 = 6;
  localparam int P28_DUPLEX   = 5;
  localparam int P29_LEDDIS   = 7;
  localparam int P29_TXDIS    = 6;
  localparam int P29_RESTART  = 5;
  localparam int P29_FEFDIS   = 4;
  localparam int P29_PWRDN    = 3;
  localparam int P29_MDIXDIS  = 2;
  localparam int P29_STRAIGHT = 1;
  localparam int P29_LOOPBACK = 0;
  localparam int P31_VARIANT  = 7;

  // management frame constants
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [5:0] OP_LAST       = 6'h01;
  localparam logic [5:0] ADDR_LAST     = 6'h09;
  localparam logic [5:0] DATA_LAST     = 6'h0f;

  typedef enum {ST_PRE, ST_START, ST_OP, ST_ADDR, ST_TA, ST_DATA} pmb_frame_st_t;

  typedef struct packed {
    logic [4:0]  phy_addr;
    logic [4:0]  reg_idx;
    logic [15:0] wdata;
  } pmb_req_t;

  typedef struct packed {
    logic loopback;
    logic force_100;
    logic autoneg_on;
    logic power_down;
    logic autoneg_restart;
    logic full_duplex;
    logic crossover_variant_select;
    logic force_straight_pinout;
    logic mdix_disable;
    logic far_fault_disable;
    logic tx_disable;
    logic led_disable;
  } pmb_ctrl_t;

  // control fields to the 16-bit register image; read-only bits are zero
  function automatic logic [15:0] ctrl_pack(input pmb_ctrl_t c);
    logic [15:0] v;
    v = 16'h0000;
    v[CB_LOOPBACK] = c.loopback;
    v[CB_FORCE100] = c.force_100;
    v[CB_AUTONEG]  = c.autoneg_on;
    v[CB_PWRDN]    = c.power_down;
    v[CB_RESTART]  = c.autoneg_restart;
    v[CB_DUPLEX]   = c.full_duplex;
    v[CB_VARIANT]  = c.crossover_variant_select;
    v[CB_STRAIGHT] = c.force_straight_pinout;
    v[CB_MDIXDIS]  = c.mdix_disable;
    v[CB_FEFDIS]   = c.far_fault_disable;
    v[CB_TXDIS]    = c.tx_disable;
    v[CB_LEDDIS]   = c.led_disable;
    return v;
  endfunction : ctrl_pack

  // register image to control fields; read-only bits are dropped
  function automatic pmb_ctrl_t ctrl_unpack(input logic [15:0] v);
    pmb_ctrl_t c;
    c.loopback                 = v[CB_LOOPBACK];
    c.force_100                = v[CB_FORCE100];
    c.autoneg_on               = v[CB_AUTONEG];
    c.power_down               = v[CB_PWRDN];
    c.autoneg_restart          = v[CB_RESTART];
    c.full_duplex              = v[CB_DUPLEX];
    c.crossover_variant_select = v[CB_VARIANT];
    c.force_straight_pinout    = v[CB_STRAIGHT];
    c.mdix_disable             = v[CB_MDIXDIS];
    c.far_fault_disable        = v[CB_FEFDIS];
    c.tx_disable               = v[CB_TXDIS];
    c.led_disable              = v[CB_LEDDIS];
    return c;
  endfunction : ctrl_unpack

endpackage : pmb_pkg

// >>> rtl/pmb_mdio_frame.sv
`timescale 1ns/1ps
module pmb_mdio_frame (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              mdc_i,
  input  wire logic              mdio_i,
  input  wire logic              hit_i,
  input  wire logic [15:0]       rdata_i,
  output logic                   mdio_o,
  output logic                   mdio_oe_o,
  output pmb_pkg::pmb_req_t      req_o,
  output logic                   wr_o
);

  pmb_pkg::pmb_frame_st_t st, next_st;
  logic [5:0]        cnt, next_cnt;
  logic              mdc_q, next_mdc_q;
  logic              is_read, next_is_read;
  logic [15:0]       shreg, next_shreg;
  pmb_pkg::pmb_req_t req, next_req;
  logic              wr, next_wr;
  logic              dout, next_dout;
  logic              oe, next_oe;
  logic              rise;

  // frame decoder, advanced on each rising edge of the management clock
  always_comb begin
    rise         = mdc_i & ~mdc_q;
    next_mdc_q   = mdc_i;
    next_st      = st;
    next_cnt     = cnt;
    next_is_read = is_read;
    next_shreg   = shreg;
    next_req     = req;
    next_wr      = 1'b0;
    next_dout    = dout;
    next_oe      = oe;
    if (rise) begin
      case (st)
        pmb_pkg::ST_PRE: begin
          if (mdio_i) begin
            if (cnt < pmb_pkg::PREAMBLE_ONES) next_cnt = cnt + 6'h01;
          end else if (cnt == pmb_pkg::PREAMBLE_ONES) begin
            next_st  = pmb_pkg::ST_START;
            next_cnt = 6'h00;
          end else begin
            next_cnt = 6'h00;
          end
        end
        pmb_pkg::ST_START: begin
          next_st  = mdio_i ? pmb_pkg::ST_OP : pmb_pkg::ST_PRE;
          next_cnt = 6'h00;
        end
        pmb_pkg::ST_OP: begin
          next_shreg = {shreg[14:0], mdio_i};
          if (cnt == pmb_pkg::OP_LAST) begin
            next_cnt     = 6'h00;
            next_is_read = ({shreg[0], mdio_i} == pmb_pkg::OP_READ);
            if (({shreg[0], mdio_i} == pmb_pkg::OP_READ) ||
                ({shreg[0], mdio_i} == pmb_pkg::OP_WRITE)) begin
              next_st = pmb_pkg::ST_ADDR;
            end else begin
              next_st = pmb_pkg::ST_PRE;
            end
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        pmb_pkg::ST_ADDR: begin
          next_shreg = {shreg[14:0], mdio_i};
          if (cnt == pmb_pkg::ADDR_LAST) begin
            next_req.phy_addr = shreg[8:4];
            next_req.reg_idx  = {shreg[3:0], mdio_i};
            next_st           = pmb_pkg::ST_TA;
            next_cnt          = 6'h00;
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        pmb_pkg::ST_TA: begin
          if (cnt == 6'h00) begin
            // first turnaround bit: take the bus and drive zero if addressed by a read
            if (is_read && hit_i) begin
              next_oe    = 1'b1;
              next_dout  = 1'b0;
              next_shreg = rdata_i;
            end
            next_cnt = 6'h01;
          end else begin
            next_dout  = oe & shreg[15];
            next_shreg = {shreg[14:0], 1'b0};
            next_st    = pmb_pkg::ST_DATA;
            next_cnt   = 6'h00;
          end
        end
        pmb_pkg::ST_DATA: begin
          if (is_read) begin
            next_dout  = oe & shreg[15];
            next_shreg = {shreg[14:0], 1'b0};
          end else begin
            next_shreg = {shreg[14:0], mdio_i};
          end
          if (cnt == pmb_pkg::DATA_LAST) begin
            next_st   = pmb_pkg::ST_PRE;
            next_cnt  = 6'h00;
            next_oe   = 1'b0;
            next_dout = 1'b0;
            if (!is_read) begin
              next_req.wdata = {shreg[14:0], mdio_i};
              next_wr        = 1'b1;
            end
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        default: begin
          next_st  = pmb_pkg::ST_PRE;
          next_cnt = 6'h00;
        end
      endcase
    end
  end

  // frame state registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st      <= pmb_pkg::ST_PRE;
      cnt     <= 6'h00;
      mdc_q   <= 1'b0;
      is_read <= 1'b0;
      shreg   <= 16'h0000;
      req     <= '0;
      wr      <= 1'b0;
      dout    <= 1'b0;
      oe      <= 1'b0;
    end else begin
      st      <= next_st;
      cnt     <= next_cnt;
      mdc_q   <= next_mdc_q;
      is_read <= next_is_read;
      shreg   <= next_shreg;
      req     <= next_req;
      wr      <= next_wr;
      dout    <= next_dout;
      oe      <= next_oe;
    end
  end

  assign mdio_o    = dout;
  assign mdio_oe_o = oe;
  assign req_o     = req;
  assign wr_o      = wr;

endmodule : pmb_mdio_frame

// >>> rtl/pmb_phy_mgmt.sv
`timescale 1ns/1ps
module pmb_phy_mgmt #(
  parameter int SYM_W = 5,
  parameter int LED_W = 2
) (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      mdc_i,
  input  wire logic                      mdio_i,
  output logic                           mdio_o,
  output logic                           mdio_oe_o,
  input  wire logic                      sw_wr_i,
  input  wire logic [7:0]                sw_addr_i,
  input  wire logic [7:0]                sw_wdata_i,
  output logic      [7:0]                sw_rdata_o,
  input  wire logic [1:0][15:0]          ext_rdata_i,
  output pmb_pkg::pmb_req_t              ext_req_o,
  output logic                           ext_phy_o,
  output logic                           ext_wr_o,
  output pmb_pkg::pmb_ctrl_t [1:0]       phy_ctrl_o,
  input  wire logic [1:0][SYM_W-1:0]     mac_tx_sym_i,
  input  wire logic [1:0][SYM_W-1:0]     line_rx_sym_i,
  output logic      [1:0][SYM_W-1:0]     line_tx_sym_o,
  input  wire logic [1:0][LED_W-1:0]     led_raw_i,
  output logic      [1:0][LED_W-1:0]     led_o
);

  pmb_pkg::pmb_req_t        req;
  logic                     mgmt_wr;
  logic                     hit;
  logic                     sel_ok;
  logic                     sel_idx;
  logic [15:0]              rdata;
  logic [4:0]               phy1_addr, next_phy1_addr;
  logic [4:0]               phy2_addr, next_phy2_addr;
  logic                     addr_prog, next_addr_prog;
  pmb_pkg::pmb_ctrl_t [1:0] ctrl, next_ctrl;
  logic [7:0]               sw_rdata, next_sw_rdata;

  // which PHY a bus address names; PHY 1 wins if both addresses coincide
  function automatic logic [1:0] phy_select(input logic [4:0] a, input logic [4:0] a1,
                                            input logic [4:0] a2);
    if (a == a1) return 2'h2;
    if (a == a2) return 2'h3;
    return 2'h0;
  endfunction : phy_select

  // register indices that exist on a given PHY
  function automatic logic reg_supported(input logic idx, input logic [4:0] r);
    return (r <= pmb_pkg::REG_LAST_STD) || (r == pmb_pkg::REG_SPECIAL) ||
           ((r == pmb_pkg::REG_CABLE_DIAG) && idx);
  endfunction : reg_supported

  // port register view of the mirrored control bits; other bits read zero
  function automatic logic [7:0] sw_view(input pmb_pkg::pmb_ctrl_t c, input logic [7:0] r);
    logic [7:0] v;
    v = 8'h00;
    case (r)
      pmb_pkg::SREG_P1_CTL28: begin
        v[pmb_pkg::P28_AUTONEG]  = c.autoneg_on;
        v[pmb_pkg::P28_FORCE100] = c.force_100;
        v[pmb_pkg::P28_DUPLEX]   = c.full_duplex;
      end
      pmb_pkg::SREG_P1_CTL29: begin
        v[pmb_pkg::P29_LEDDIS]   = c.led_disable;
        v[pmb_pkg::P29_TXDIS]    = c.tx_disable;
        v[pmb_pkg::P29_RESTART]  = c.autoneg_restart;
        v[pmb_pkg::P29_FEFDIS]   = c.far_fault_disable;
        v[pmb_pkg::P29_PWRDN]    = c.power_down;
        v[pmb_pkg::P29_MDIXDIS]  = c.mdix_disable;
        v[pmb_pkg::P29_STRAIGHT] = c.force_straight_pinout;
        v[pmb_pkg::P29_LOOPBACK] = c.loopback;
      end
      pmb_pkg::SREG_P1_CTL31: v[pmb_pkg::P31_VARIANT] = c.crossover_variant_select;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : sw_view

  // merge a port register write into the control bits it mirrors
  function automatic pmb_pkg::pmb_ctrl_t sw_merge(input pmb_pkg::pmb_ctrl_t c,
                                                  input logic [7:0] r, input logic [7:0] d);
    pmb_pkg::pmb_ctrl_t n;
    n = c;
    case (r)
      pmb_pkg::SREG_P1_CTL28: begin
        n.autoneg_on  = d[pmb_pkg::P28_AUTONEG];
        n.force_100   = d[pmb_pkg::P28_FORCE100];
        n.full_duplex = d[pmb_pkg::P28_DUPLEX];
      end
      pmb_pkg::SREG_P1_CTL29: begin
        n.led_disable           = d[pmb_pkg::P29_LEDDIS];
        n.tx_disable            = d[pmb_pkg::P29_TXDIS];
        n.autoneg_restart       = d[pmb_pkg::P29_RESTART];
        n.far_fault_disable     = d[pmb_pkg::P29_FEFDIS];
        n.power_down            = d[pmb_pkg::P29_PWRDN];
        n.mdix_disable          = d[pmb_pkg::P29_MDIXDIS];
        n.force_straight_pinout = d[pmb_pkg::P29_STRAIGHT];
        n.loopback              = d[pmb_pkg::P29_LOOPBACK];
      end
      pmb_pkg::SREG_P1_CTL31: n.crossover_variant_select = d[pmb_pkg::P31_VARIANT];
      default: n = c;
    endcase
    return n;
  endfunction : sw_merge

  // management frame engine
  pmb_mdio_frame u_frame (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .mdc_i     (mdc_i),
    .mdio_i    (mdio_i),
    .hit_i     (hit),
    .rdata_i   (rdata),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o),
    .req_o     (req),
    .wr_o      (mgmt_wr)
  );

  // address decode and read data for the pending management access
  always_comb begin
    {sel_ok, sel_idx} = phy_select(req.phy_addr, phy1_addr, phy2_addr);
    hit   = sel_ok && reg_supported(sel_idx, req.reg_idx);
    rdata = 16'h0000;
    if (hit) begin
      if (req.reg_idx == pmb_pkg::REG_CONTROL) begin
        rdata = pmb_pkg::ctrl_pack(ctrl[sel_idx]);
      end else begin
        rdata = ext_rdata_i[sel_idx];
      end
    end
  end

  // other supported registers are served outside; only writes that hit them are passed on
  assign ext_req_o = req;
  assign ext_phy_o = sel_idx;
  assign ext_wr_o  = mgmt_wr && hit && (req.reg_idx != pmb_pkg::REG_CONTROL);

  // next state of addresses, control bits and the switch-side read port
  always_comb begin
    next_phy1_addr = phy1_addr;
    next_phy2_addr = phy2_addr;
    next_addr_prog = addr_prog;
    next_ctrl      = ctrl;
    next_sw_rdata  = 8'h00;
    for (int k = 0; k < 2; k++) begin
      next_ctrl[k].autoneg_restart = 1'b0;
      if (sw_wr_i) begin
        next_ctrl[k] = sw_merge(next_ctrl[k],
                                sw_addr_i - 8'(k * pmb_pkg::SREG_PHY_STRIDE),
                                sw_wdata_i);
      end
      if (sw_addr_i >= 8'(k * pmb_pkg::SREG_PHY_STRIDE) + pmb_pkg::SREG_P1_CTL28) begin
        next_sw_rdata = next_sw_rdata |
                        sw_view(ctrl[k], sw_addr_i - 8'(k * pmb_pkg::SREG_PHY_STRIDE));
      end
    end
    // far-end fault disable has no port register 45 copy
    if (sw_wr_i && (sw_addr_i == pmb_pkg::SREG_P1_CTL29 + pmb_pkg::SREG_PHY_STRIDE)) begin
      next_ctrl[1].far_fault_disable = ctrl[1].far_fault_disable;
    end
    if (sw_addr_i == pmb_pkg::SREG_P1_CTL29 + pmb_pkg::SREG_PHY_STRIDE) begin
      next_sw_rdata[pmb_pkg::P29_FEFDIS] = 1'b0;
    end
    if (sw_addr_i == pmb_pkg::SREG_GLOBAL_ADDR) begin
      next_sw_rdata[pmb_pkg::ADDR_FIELD_MSB:pmb_pkg::ADDR_FIELD_LSB] = phy1_addr;
    end
    if (sw_wr_i && (sw_addr_i == pmb_pkg::SREG_GLOBAL_ADDR)) begin
      next_phy1_addr = sw_wdata_i[pmb_pkg::ADDR_FIELD_MSB:pmb_pkg::ADDR_FIELD_LSB];
      next_phy2_addr = sw_wdata_i[pmb_pkg::ADDR_FIELD_MSB:pmb_pkg::ADDR_FIELD_LSB] + 5'h01;
      next_addr_prog = 1'b1;
    end
    // management write lands after the switch-side write
    if (mgmt_wr && hit && (req.reg_idx == pmb_pkg::REG_CONTROL)) begin
      next_ctrl[sel_idx] = pmb_pkg::ctrl_unpack(req.wdata);
    end
  end

  // address and control registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phy1_addr <= pmb_pkg::PHY1_ADDR_RST;
      phy2_addr <= pmb_pkg::PHY2_ADDR_RST;
      addr_prog <= 1'b0;
      ctrl[0]   <= pmb_pkg::ctrl_unpack(pmb_pkg::CTRL_RST);
      ctrl[1]   <= pmb_pkg::ctrl_unpack(pmb_pkg::CTRL_RST);
      sw_rdata  <= 8'h00;
    end else begin
      phy1_addr <= next_phy1_addr;
      phy2_addr <= next_phy2_addr;
      addr_prog <= next_addr_prog;
      ctrl      <= next_ctrl;
      sw_rdata  <= next_sw_rdata;
    end
  end

  assign sw_rdata_o = sw_rdata;
  assign phy_ctrl_o = ctrl;

  // per-PHY transmit path and LED gating
  for (genvar j = 0; j < 2; j++) begin : g_port
    localparam int OTH = 1 - j;
    logic [SYM_W-1:0] tx_q, next_tx;
    logic [LED_W-1:0] led_q, next_led;
    always_comb begin
      next_tx  = ctrl[OTH].loopback ? line_rx_sym_i[j] : mac_tx_sym_i[j];
      if (ctrl[j].tx_disable) next_tx = '0;
      next_led = ctrl[j].led_disable ? '0 : led_raw_i[j];
    end
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        tx_q  <= '0;
        led_q <= '0;
      end else begin
        tx_q  <= next_tx;
        led_q <= next_led;
      end
    end
    assign line_tx_sym_o[j] = tx_q;
    assign led_o[j]         = led_q;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_ctrl_write(int k);
    mgmt_wr && hit && (req.reg_idx == pmb_pkg::REG_CONTROL) && (sel_idx == k);
  endsequence

  a_default_addr: assert property (
      !addr_prog |-> (phy1_addr == 5'h01) && (phy2_addr == 5'h02))
    else $error("default phy addresses lost");
  a_addr_reprog: assert property (
      sw_wr_i && (sw_addr_i == 8'h0f) |=>
      (phy1_addr == $past(sw_wdata_i[7:3])) && addr_prog)
    else $error("phy address field not taken");
  a_diag_only_phy2: assert property (
      sel_ok && !sel_idx && (req.reg_idx == 5'h1d) |-> !hit)
    else $error("cable diag index answered on phy 1");
  a_sw_loop_mirror: assert property (
      sw_wr_i && (sw_addr_i == 8'h2d) && !mgmt_wr |=>
      ctrl[1].loopback == $past(sw_wdata_i[0]))
    else $error("port loopback mirror broken");
  a_ctrl_write: assert property (
      s_ctrl_write(0) |=> (pmb_pkg::ctrl_pack(ctrl[0]) & 16'h793f) ==
      ($past(req.wdata) & 16'h793f))
    else $error("control write not stored");
  a_loop_path: assert property (
      ctrl[1].loopback && !ctrl[0].tx_disable |=>
      line_tx_sym_o[0] == $past(line_rx_sym_i[0]))
    else $error("loopback path not wrapped");
  a_restart_pulse: assert property (ctrl[0].autoneg_restart |=> !ctrl[0].autoneg_restart)
    else $error("restart did not self clear");
  a_tx_off: assert property (ctrl[0].tx_disable |=> line_tx_sym_o[0] == '0)
    else $error("transmitter not disabled");
  a_led_off: assert property (ctrl[0].led_disable |=> led_o[0] == '0)
    else $error("led not turned off");
  a_ro_zero: assert property (
      hit && (req.reg_idx == 5'h00) |-> (rdata & 16'h84c0) == 16'h0000)
    else $error("read-only control bits not zero");
  a_miss_zero: assert property (!hit |-> (rdata == 16'h0000) && !ext_wr_o)
    else $error("unsupported access not ignored");
  a_reset_vals: assert property (
      $fell(sys_rst_i) |->
      ctrl[1].autoneg_on && ctrl[1].crossover_variant_select && !ctrl[1].power_down)
    else $error("control reset value wrong");

endmodule : pmb_phy_mgmt

// >>> verification/pmb_mdio_master.sv
`timescale 1ns/1ps
module pmb_mdio_master (
  input  wire logic clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  // idle: clock stands low, line released
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // one mdc period of four clocks; data moves only while mdc is low
  task automatic put_bit(input logic b, output logic s);
    mdio_o = b;
    repeat (2) @(posedge clk_i);
    #1 s = mdio_i;
    mdc_o = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 mdc_o = 1'b0;
  endtask : put_bit
  // whole frame with fresh preamble; line released from turnaround on reads
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic        s;
    f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    mdio_oe_o = 1'b1;
    for (int i = 63; i >= 0; i--) begin
      if (i == 17 && op == pmb_pkg::OP_READ) mdio_oe_o = 1'b0;
      put_bit(f[i], s);
      if (i < 16) rd[i] = s;
    end
    mdio_oe_o = 1'b0;
  endtask : frame
endmodule : pmb_mdio_master

// >>> verification/test_pmb_phy_mgmt.sv
`timescale 1ns/1ps
module test_pmb_phy_mgmt;
  logic                     clk_i     = 1'b0;
  logic                     sys_rst_i = 1'b1;
  logic                     sw_wr_i   = 1'b0;
  logic [7:0]               sw_addr_i = 8'h00;
  logic [7:0]               sw_wdata  = 8'h00;
  logic [1:0][15:0]         ext_rdata = {16'h5678, 16'h1234};
  logic [1:0][4:0]          mac_tx    = {5'h0c, 5'h0a};
  logic [1:0][4:0]          line_rx   = {5'h13, 5'h15};
  logic [1:0][1:0]          led_raw   = 4'hb;
  logic                     mdc, m_mdio, m_oe, d_mdio, d_oe, mdio_w;
  logic [7:0]               sw_rdata;
  logic [1:0][4:0]          line_tx;
  logic [1:0][1:0]          led;
  pmb_pkg::pmb_ctrl_t [1:0] ctrl;
  logic [15:0]              q;
  pmb_pkg::pmb_req_t        ext_req;
  logic                     ext_phy, ext_wr;
  logic [21:0]              ext_last   = '0;
  int                       ext_wr_cnt = 0;
  int                       err_total = 0;
  int                       cmp_count = 0;
  // shared line with pull-up
  assign mdio_w = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);
  // capture of writes handed to the outside register holders
  always @(posedge clk_i) begin
    if (ext_wr) begin
      ext_wr_cnt <= ext_wr_cnt + 1;
      ext_last   <= {ext_phy, ext_req.reg_idx, ext_req.wdata};
    end
  end
  always #20 clk_i = ~clk_i;
  pmb_phy_mgmt u_pmb_phy_mgmt (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mdc_i(mdc),
    .mdio_i(mdio_w), .mdio_o(d_mdio), .mdio_oe_o(d_oe), .sw_wr_i(sw_wr_i),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata), .sw_rdata_o(sw_rdata),
    .ext_rdata_i(ext_rdata), .ext_req_o(ext_req), .ext_phy_o(ext_phy), .ext_wr_o(ext_wr),
    .phy_ctrl_o(ctrl),
    .mac_tx_sym_i(mac_tx), .line_rx_sym_i(line_rx), .line_tx_sym_o(line_tx),
    .led_raw_i(led_raw), .led_o(led));
  pmb_mdio_master u_pmb_mdio_master (.clk_i(clk_i), .mdio_i(mdio_w), .mdc_o(mdc),
    .mdio_o(m_mdio), .mdio_oe_o(m_oe));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %0s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [4:0] pa, input logic [4:0] ra);
    u_pmb_mdio_master.frame(pmb_pkg::OP_READ, pa, ra, 16'h0000, q);
  endtask : rd
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    u_pmb_mdio_master.frame(pmb_pkg::OP_WRITE, pa, ra, d, q);
  endtask : wr
  // switch-side access: one-clock strobe, read data one clock later
  task automatic sw(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 sw_wr_i = w;
    sw_addr_i = a;
    sw_wdata = d;
    @(posedge clk_i);
    #1 sw_wr_i = 1'b0;
    q = {8'h00, sw_rdata};
  endtask : sw
  task automatic rst;
    sys_rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
  endtask : rst
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // hang guard, about ten times the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    $display("mismatch at %0t: run timed out", $time);
    print_verdict();
  end
  initial begin
    rst();
    rd(5'h01, 5'h00);
    cmp(q, 16'h1020, "phy1 reset image");
    rd(5'h02, 5'h00);
    cmp(q, 16'h1020, "phy2 reset image");
    cmp({4'h0, ctrl[1]}, 16'h0220, "phy2 ctrl reset");
    $display("test reset done");
    sw(1'b1, 8'h2d, 8'h01);
    rd(5'h02, 5'h00);
    cmp(q, 16'h5020, "phy2 loopback via port reg");
    cmp({11'h0, line_tx[0]}, 16'h0015, "wrapped receive");
    cmp({11'h0, line_tx[1]}, 16'h000c, "plain transmit");
    $display("test loopback done");
    wr(5'h01, 5'h00, 16'hffff);
    rd(5'h01, 5'h00);
    cmp(q, 16'h793f, "phy1 all ones");
    sw(1'b0, 8'h1c, 8'h00);
    cmp(q, 16'h00e0, "mirror 28");
    sw(1'b0, 8'h1d, 8'h00);
    cmp(q, 16'h00df, "mirror 29");
    sw(1'b0, 8'h1f, 8'h00);
    cmp(q, 16'h0080, "mirror 31");
    cmp({11'h0, line_tx[0]}, 16'h0000, "tx disabled");
    cmp({14'h0, led[0]}, 16'h0000, "led off");
    cmp({14'h0, led[1]}, 16'h0002, "led on");
    $display("test control write done");
    rd(5'h01, 5'h1d);
    cmp(q, 16'hffff, "phy1 index 29 silent");
    rd(5'h02, 5'h1d);
    cmp(q, 16'h5678, "phy2 index 29");
    rd(5'h01, 5'h1f);
    cmp(q, 16'h1234, "phy1 index 31");
    rd(5'h01, 5'h06);
    cmp(q, 16'hffff, "index 6 silent");
    wr(5'h02, 5'h1f, 16'h0a5c);
    cmp(16'(ext_wr_cnt), 16'h0001, "one outside write");
    cmp({10'h000, ext_last[21:16]}, 16'h003f, "outside write target");
    cmp(ext_last[15:0], 16'h0a5c, "outside write data");
    wr(5'h01, 5'h06, 16'h1111);
    wr(5'h01, 5'h1d, 16'h2222);
    cmp(16'(ext_wr_cnt), 16'h0001, "unsupported writes ignored");
    $display("test indices done");
    rst();
    sw(1'b1, 8'h0f, 8'h28);
    sw(1'b0, 8'h0f, 8'h00);
    cmp(q, 16'h0028, "address field");
    rd(5'h05, 5'h00);
    cmp(q, 16'h1020, "phy1 at 5");
    rd(5'h06, 5'h00);
    cmp(q, 16'h1020, "phy2 at 6");
    rd(5'h01, 5'h00);
    cmp(q, 16'hffff, "old address silent");
    $display("test address move done");
    print_verdict();
  end
endmodule : test_pmb_phy_mgmt
